// *** rail_control_consts.vh ***
// Constants for the rail control pin block
`ifndef RAIL_CONTROL_CONSTS_VH
`define RAIL_CONTROL_CONSTS_VH

// Number of regulators controlled
`define NUM_RAILS 12

// Register byte offsets
`define OFS_ENABLE_MAP_0 12'h000
`define OFS_SLEEP_CFG 12'h018
`define OFS_OUT_CFG 12'h01c
`define OFS_PG_MASK_0 12'h020
`define OFS_IRQ_CTRL 12'h030
`define OFS_RAIL_STATE 12'h034
`define OFS_PIN_STATE 12'h038
`define OFS_VSEL_NORMAL 12'h03c
`define OFS_VSEL_SLEEP 12'h040

// Sleep configuration fields
`define SLEEP_A_EN_BIT 0
`define SLEEP_B_EN_BIT 1
`define SLEEP_A_MAP_LSB 4
`define SLEEP_B_MAP_LSB 16

// Output configuration fields
`define OUT_SRC_PG_LSB 0
`define OUT_PUSHPULL_LSB 4
`define OUT_REGBIT_LSB 8

// Reset values
`define RST_SLEEP_CFG 32'h0000_0000
`define RST_OUT_CFG 32'h0000_0000
`define RST_ENABLE_MAP 12'h000
`define RST_PG_MASK 12'h000

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** status_pin_driver.v ***
// One general-purpose status output: source select and drive style
`timescale 1ns/100ps
module status_pin_driver #(
	parameter PUSHPULL_ALLOWED = 1
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Configuration
	input wire src_is_pg,
	input wire push_pull,
	input wire reg_bit,
	input wire [11:0] pg_mask,
	input wire [11:0] rail_good,
	// Pin
	output reg pin_o,
	output reg pin_oe_n
);

	wire pg_all;
	wire level;
	wire pp_eff;

	// Combined good over chosen set; empty set reads good
	assign pg_all = &(rail_good | ~pg_mask);
	assign level = src_is_pg ? pg_all : reg_bit;
	assign pp_eff = (PUSHPULL_ALLOWED != 0) ? push_pull : 1'b0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_o <= 1'b0;
			pin_oe_n <= 1'b1;
		end else if (pp_eff) begin
			pin_o <= level;
			pin_oe_n <= 1'b0;
		end else begin
			// Open drain: drive low only, release for high
			pin_o <= 1'b0;
			pin_oe_n <= level;
		end
	end

endmodule

// *** rail_control_pins.v ***
// Control-pin logic: rail enables, sleep entry, status outputs, interrupt pin
// What this block does
// - Enable pin high turns its group on, except pin three or six while in sleep mode
// - Pins three, six may be low-active sleep
// - Sleeping regulators use their sleep voltage setting
// - First three outputs: open-drain or push-pull
// - Outputs can show combined power-good of set
// - Outputs can follow a host register bit
// - Fourth output always open-drain
// - Interrupt pin open-drain, low when pending and unmasked, or when forced
`timescale 1ns/100ps
`include "rail_control_consts.vh"
module rail_control_pins (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Rail enable pins
	input wire rail_enable_in_1,
	input wire rail_enable_in_2,
	input wire rail_enable_in_3,
	input wire rail_enable_in_4,
	input wire rail_enable_in_5,
	input wire rail_enable_in_6,
	// Regulator side
	input wire [11:0] rail_good,
	input wire irq_pending,
	output reg [11:0] rail_on_q,
	output reg [11:0] rail_sleep_q,
	output reg [11:0] rail_vsel_sleep_q,
	// Status outputs
	output wire status_out_1_o,
	output wire status_out_1_oe_n,
	output wire status_out_2_o,
	output wire status_out_2_oe_n,
	output wire status_out_3_o,
	output wire status_out_3_oe_n,
	output wire status_out_4_o,
	output wire status_out_4_oe_n,
	// Interrupt pin
	output reg interrupt_out_n_o,
	output reg interrupt_out_n_oe_n
);

	// ==========================================================
	// Registers
	reg [11:0] enable_map_q [0:5];
	reg [11:0] pg_mask_q [0:3];
	reg [31:0] sleep_cfg_q;
	reg [31:0] out_cfg_q;
	reg irq_force_q;
	reg irq_mask_q;
	reg [11:0] vsel_normal_q;
	reg [11:0] vsel_sleep_q;

	wire [5:0] en_pins;
	wire sleep_entry_n_a;
	wire sleep_entry_n_b;
	wire sleep_a_on;
	wire sleep_b_on;
	wire [11:0] sleep_a_map;
	wire [11:0] sleep_b_map;

	assign en_pins = {rail_enable_in_6, rail_enable_in_5, rail_enable_in_4,
		rail_enable_in_3, rail_enable_in_2, rail_enable_in_1};
	assign sleep_entry_n_a = rail_enable_in_3;
	assign sleep_entry_n_b = rail_enable_in_6;
	assign sleep_a_on = sleep_cfg_q[`SLEEP_A_EN_BIT];
	assign sleep_b_on = sleep_cfg_q[`SLEEP_B_EN_BIT];
	assign sleep_a_map = sleep_cfg_q[`SLEEP_A_MAP_LSB +: 12];
	assign sleep_b_map = sleep_cfg_q[`SLEEP_B_MAP_LSB +: 12];

	// ==========================================================
	// Rail enable and sleep control
	reg [11:0] on_d;
	reg [11:0] sleep_d;
	integer i;

	always @* begin
		on_d = 12'h000;
		for (i = 0; i < 6; i = i + 1) begin
			// Pins in sleep mode do not act as enables
			if (en_pins[i] && !((i == 2 && sleep_a_on) || (i == 5 && sleep_b_on)))
				on_d = on_d | enable_map_q[i];
		end
		sleep_d = 12'h000;
		if (sleep_a_on && !sleep_entry_n_a)
			sleep_d = sleep_d | sleep_a_map;
		if (sleep_b_on && !sleep_entry_n_b)
			sleep_d = sleep_d | sleep_b_map;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rail_on_q <= 12'h000;
			rail_sleep_q <= 12'h000;
			rail_vsel_sleep_q <= 12'h000;
		end else begin
			rail_on_q <= on_d;
			rail_sleep_q <= sleep_d & on_d;
			// Per rail: sleep voltage set while its sleep pin is low (even if the rail is off), else normal set
			rail_vsel_sleep_q <= (sleep_d & vsel_sleep_q) | (~sleep_d & vsel_normal_q);
		end
	end

	// ==========================================================
	// Status outputs
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_out
			wire o_w;
			wire oe_w;
			status_pin_driver #(
				.PUSHPULL_ALLOWED(g < 3 ? 1 : 0)
			) u_drv (
				.aclk(aclk),
				.aresetn(aresetn),
				.src_is_pg(out_cfg_q[`OUT_SRC_PG_LSB + g]),
				.push_pull(out_cfg_q[`OUT_PUSHPULL_LSB + g]),
				.reg_bit(out_cfg_q[`OUT_REGBIT_LSB + g]),
				.pg_mask(pg_mask_q[g]),
				.rail_good(rail_good),
				.pin_o(o_w),
				.pin_oe_n(oe_w)
			);
		end
	endgenerate

	assign status_out_1_o = gen_out[0].o_w;
	assign status_out_1_oe_n = gen_out[0].oe_w;
	assign status_out_2_o = gen_out[1].o_w;
	assign status_out_2_oe_n = gen_out[1].oe_w;
	assign status_out_3_o = gen_out[2].o_w;
	assign status_out_3_oe_n = gen_out[2].oe_w;
	assign status_out_4_o = gen_out[3].o_w;
	assign status_out_4_oe_n = gen_out[3].oe_w;

	// ==========================================================
	// Interrupt pin
	always @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_out_n_o <= 1'b0;
			interrupt_out_n_oe_n <= 1'b1;
		end else begin
			interrupt_out_n_o <= 1'b0;
			// Pull low when pending and unmasked, or when forced, else release
			interrupt_out_n_oe_n <= !(((irq_pending && !irq_mask_q) || irq_force_q));
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	reg aw_held_q;
	reg w_held_q;
	reg [11:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	wire [11:0] wa;
	wire [31:0] wd;
	wire [3:0] ws;
	wire aw_have;
	wire w_have;
	wire do_write;
	reg hit_w;
	integer k;

	assign aw_have = aw_held_q || (s_axi_awvalid && s_axi_awready);
	assign w_have = w_held_q || (s_axi_wvalid && s_axi_wready);
	assign do_write = aw_have && w_have && !s_axi_bvalid;
	assign wa = aw_held_q ? aw_addr_q : s_axi_awaddr;
	assign wd = w_held_q ? w_data_q : s_axi_wdata;
	assign ws = w_held_q ? w_strb_q : s_axi_wstrb;

	function [31:0] apply_strb;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] st;
		integer b;
		begin
			apply_strb = old;
			for (b = 0; b < 4; b = b + 1)
				if (st[b])
					apply_strb[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	always @* begin
		hit_w = (wa[11:2] <= 10'd16) && (wa[1:0] == 2'b00);
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			for (k = 0; k < 6; k = k + 1)
				enable_map_q[k] <= `RST_ENABLE_MAP;
			for (k = 0; k < 4; k = k + 1)
				pg_mask_q[k] <= `RST_PG_MASK;
			sleep_cfg_q <= `RST_SLEEP_CFG;
			out_cfg_q <= `RST_OUT_CFG;
			irq_force_q <= 1'b0;
			irq_mask_q <= 1'b0;
			vsel_normal_q <= 12'h000;
			vsel_sleep_q <= 12'h000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_awaddr;
				aw_held_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_held_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= hit_w ? `RESP_OKAY : `RESP_SLVERR;
				for (k = 0; k < 6; k = k + 1)
					if (wa == {k[9:0], 2'b00})
						enable_map_q[k] <= {ws[1] ? wd[11:8] : enable_map_q[k][11:8],
							ws[0] ? wd[7:0] : enable_map_q[k][7:0]};
				for (k = 0; k < 4; k = k + 1)
					if (wa == {k[9:0] + 10'd8, 2'b00})
						pg_mask_q[k] <= {ws[1] ? wd[11:8] : pg_mask_q[k][11:8],
							ws[0] ? wd[7:0] : pg_mask_q[k][7:0]};
				if (wa == `OFS_SLEEP_CFG)
					sleep_cfg_q <= apply_strb(sleep_cfg_q, wd, ws);
				if (wa == `OFS_OUT_CFG)
					out_cfg_q <= apply_strb(out_cfg_q, wd, ws);
				if (wa == `OFS_IRQ_CTRL && ws[0]) begin
					irq_force_q <= wd[0];
					irq_mask_q <= wd[1];
				end
				if (wa == `OFS_VSEL_NORMAL)
					vsel_normal_q <= {ws[1] ? wd[11:8] : vsel_normal_q[11:8],
						ws[0] ? wd[7:0] : vsel_normal_q[7:0]};
				if (wa == `OFS_VSEL_SLEEP)
					vsel_sleep_q <= {ws[1] ? wd[11:8] : vsel_sleep_q[11:8],
						ws[0] ? wd[7:0] : vsel_sleep_q[7:0]};
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	reg [31:0] rd_d;
	reg rd_hit;

	always @* begin
		rd_d = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			12'h000: rd_d = {20'h00000, enable_map_q[0]};
			12'h004: rd_d = {20'h00000, enable_map_q[1]};
			12'h008: rd_d = {20'h00000, enable_map_q[2]};
			12'h00c: rd_d = {20'h00000, enable_map_q[3]};
			12'h010: rd_d = {20'h00000, enable_map_q[4]};
			12'h014: rd_d = {20'h00000, enable_map_q[5]};
			`OFS_SLEEP_CFG: rd_d = sleep_cfg_q;
			`OFS_OUT_CFG: rd_d = out_cfg_q;
			12'h020: rd_d = {20'h00000, pg_mask_q[0]};
			12'h024: rd_d = {20'h00000, pg_mask_q[1]};
			12'h028: rd_d = {20'h00000, pg_mask_q[2]};
			12'h02c: rd_d = {20'h00000, pg_mask_q[3]};
			`OFS_IRQ_CTRL: rd_d = {30'h0000_0000, irq_mask_q, irq_force_q};
			`OFS_RAIL_STATE: rd_d = {4'h0, rail_sleep_q, 4'h0, rail_on_q};
			`OFS_PIN_STATE: rd_d = {4'h0, rail_good, 5'h00, ~interrupt_out_n_oe_n,
				status_out_4_oe_n, status_out_3_o, status_out_2_o, status_out_1_o, en_pins};
			`OFS_VSEL_NORMAL: rd_d = {20'h00000, vsel_normal_q};
			`OFS_VSEL_SLEEP: rd_d = {20'h00000, vsel_sleep_q};
			default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// *** rail_control_pins_asserts.sv ***
// Checker for the rail control pin block
`timescale 1ns/100ps
module rail_control_pins_asserts (
	// Clock and reset
	input logic aclk,
	input logic aresetn,
	// Register bus
	input logic s_axi_awready,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	// Pins and regulators
	input logic rail_enable_in_1,
	input logic rail_enable_in_2,
	input logic rail_enable_in_3,
	input logic rail_enable_in_4,
	input logic rail_enable_in_5,
	input logic rail_enable_in_6,
	input logic [11:0] rail_on_q,
	input logic [11:0] rail_sleep_q,
	input logic status_out_4_o,
	input logic status_out_4_oe_n,
	input logic interrupt_out_n_o
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_enable_idle: assert property ({rail_enable_in_1, rail_enable_in_2, rail_enable_in_3,
		rail_enable_in_4, rail_enable_in_5, rail_enable_in_6} == 6'h00 |=> rail_on_q == 12'h000)
		else $error("rail on with all enables low");
	a_sleep_needs_on: assert property ((rail_sleep_q & ~rail_on_q) == 12'h000)
		else $error("sleep on a rail that is off");
	a_sleep_pin_high: assert property (rail_enable_in_3 && rail_enable_in_6 |=> rail_sleep_q == 12'h000)
		else $error("sleep with both sleep pins high");
	a_out4_drain: assert property (!status_out_4_oe_n |-> !status_out_4_o)
		else $error("output four driven high");
	a_irq_drain: assert property (interrupt_out_n_o == 1'b0)
		else $error("interrupt pin driven high");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
endmodule
bind rail_control_pins rail_control_pins_asserts u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rail_enable_in_1, .rail_enable_in_2,
	.rail_enable_in_3, .rail_enable_in_4, .rail_enable_in_5, .rail_enable_in_6, .rail_on_q, .rail_sleep_q,
	.status_out_4_o, .status_out_4_oe_n, .interrupt_out_n_o);

// *** host_pins.sv ***
// Host-side model of the board lines
`timescale 1ns/100ps
module host_pins (
	// Pins from the device
	input logic [3:0] so,
	input logic [3:0] soe_n,
	input logic io,
	input logic ioe_n,
	// Levels on the board
	output logic [3:0] line,
	output logic irq_line
);
	// Released lines float up to the pull-up level
	assign line = so | soe_n;
	assign irq_line = io | ioe_n;
endmodule

// *** rail_control_pins_tb.sv ***
// Testbench for the rail control pin block
`timescale 1ns/100ps
`include "rail_control_consts.vh"
module rail_control_pins_tb;
	logic aclk = 0, aresetn = 0, irq_pending = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, rail_good = 0;
	logic [31:0] s_axi_wdata = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [5:0] en = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [11:0] rail_on_q, rail_sleep_q, rail_vsel_sleep_q;
	wire status_out_1_o, status_out_2_o, status_out_3_o, status_out_4_o, interrupt_out_n_o;
	wire status_out_1_oe_n, status_out_2_oe_n, status_out_3_oe_n, status_out_4_oe_n, interrupt_out_n_oe_n;
	wire [3:0] line;
	wire irq_line;
	int error_cnt = 0, n_compared = 0, cyc = 0;
	always #12.5 aclk = ~aclk;
	rail_control_pins u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rail_enable_in_1(en[0]), .rail_enable_in_2(en[1]), .rail_enable_in_3(en[2]),
		.rail_enable_in_4(en[3]), .rail_enable_in_5(en[4]), .rail_enable_in_6(en[5]), .rail_good,
		.irq_pending, .rail_on_q, .rail_sleep_q, .rail_vsel_sleep_q, .status_out_1_o, .status_out_1_oe_n,
		.status_out_2_o, .status_out_2_oe_n, .status_out_3_o, .status_out_3_oe_n, .status_out_4_o,
		.status_out_4_oe_n, .interrupt_out_n_o, .interrupt_out_n_oe_n);
	host_pins u_host (.so({status_out_4_o, status_out_3_o, status_out_2_o, status_out_1_o}),
		.soe_n({status_out_4_oe_n, status_out_3_oe_n, status_out_2_oe_n, status_out_1_oe_n}),
		.io(interrupt_out_n_o), .ioe_n(interrupt_out_n_oe_n), .line, .irq_line);
	// ==========
	// Tasks
	task print_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, `RESP_OKAY);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk(s_axi_rresp, r);
		if (r == `RESP_OKAY) chk(s_axi_rdata, d);
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict;
		end
	end
	// ==========
	// Tests
	initial begin
		tick(10);
		aresetn <= 1;
		rd(`OFS_OUT_CFG, `RST_OUT_CFG, `RESP_OKAY);
		rd(12'h044, 0, `RESP_SLVERR);
		wr(`OFS_ENABLE_MAP_0, 32'h00f);
		wr(`OFS_ENABLE_MAP_0 + 12'h014, 32'hc00);
		rd(`OFS_ENABLE_MAP_0, 32'h00f, `RESP_OKAY);
		en <= 6'h21;
		tick(2);
		chk(rail_on_q, 12'hc0f);
		en <= 6'h00;
		tick(2);
		chk(rail_on_q, 12'h000);
		wr(`OFS_VSEL_NORMAL, 32'h0f0);
		wr(`OFS_VSEL_SLEEP, 32'h00f);
		wr(`OFS_SLEEP_CFG, 32'h0f1);
		en <= 6'h01;
		tick(2);
		chk(rail_sleep_q, 12'h00f);
		chk(rail_vsel_sleep_q, 12'h0ff);
		rd(`OFS_RAIL_STATE, 32'h000f_000f, `RESP_OKAY);
		en <= 6'h25;
		tick(2);
		chk(rail_sleep_q, 12'h000);
		chk(rail_vsel_sleep_q, 12'h0f0);
		wr(`OFS_ENABLE_MAP_0 + 12'h004, 32'hc00);
		wr(`OFS_SLEEP_CFG, 32'h0c00_0002);
		en <= 6'h02;
		tick(2);
		chk({rail_sleep_q, rail_on_q}, 24'hc00c00);
		en <= 6'h22;
		tick(2);
		chk(rail_sleep_q, 12'h000);
		wr(`OFS_SLEEP_CFG, 32'h0);
		wr(`OFS_PG_MASK_0 + 12'h004, 32'h003);
		wr(`OFS_PG_MASK_0 + 12'h00c, 32'h00c);
		wr(`OFS_PIN_STATE, 32'h0);
		rd(`OFS_PG_MASK_0 + 12'h00c, 32'h00c, `RESP_OKAY);
		rail_good <= 12'h001;
		wr(`OFS_OUT_CFG, 32'h992);
		tick(2);
		chk({status_out_1_oe_n, status_out_1_o}, 2'b01);
		chk(line, 4'b1001);
		chk(status_out_4_oe_n, 1'b1);
		rail_good <= 12'h003;
		wr(`OFS_OUT_CFG, 32'h192);
		tick(2);
		chk(line, 4'b0011);
		chk({status_out_4_oe_n, status_out_3_oe_n, status_out_2_oe_n}, 3'b001);
		rd(`OFS_PIN_STATE, 32'h0003_0062, `RESP_OKAY);
		irq_pending <= 1;
		tick(2);
		chk({irq_line, interrupt_out_n_oe_n}, 2'b00);
		irq_pending <= 0;
		tick(2);
		chk(irq_line, 1'b1);
		wr(`OFS_IRQ_CTRL, 32'h1);
		tick(2);
		chk(irq_line, 1'b0);
		wr(`OFS_IRQ_CTRL, 32'h2);
		irq_pending <= 1;
		tick(2);
		chk(irq_line, 1'b1);
		print_verdict;
	end
endmodule
